// [rtl/lsc_pkg.sv]
// Shared constants, types and helpers for the light sensor config block
// Contract
// - Mask zeroes exponent in manual ranges
// - Config write aborts running conversion
// - Restart conversion if new setting asks
// - Config register resets to C810h
// - Range field uses exponent code meanings
// - Auto range reports chosen range code
// - Range field powers up in auto
// - Conversion time bit picks 100/800 ms
// - Short conversion drops low result bits in ranges 0 to 5
// - Result layout same for both times
// - Mode field: shutdown, single, continuous
// - Mode field resets to shutdown
// - Single shot clears mode when done
// - Shutdown keeps flags unchanged
// - Done flag set at end, cleared by config read or starting write
package lsc_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_FREQ_HZ   = 25_000_000; // Core rate
  localparam int unsigned MS_PER_SEC    = 1000;       // ms per s
  localparam int unsigned SHORT_CONV_MS = 100;        // Short time
  localparam int unsigned LONG_CONV_MS  = 800;        // Long time
  localparam int unsigned CONV_MS_W     = 10;         // ms counter

  // ==========================================================
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_RESULT     = 8'h00;
  localparam logic [7:0] IDX_CONFIG     = 8'h01;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h04;
  localparam logic [7:0] IDX_IRQ_MASK   = 8'h05;

  // ==========================================================
  // Config register layout
  localparam logic [15:0] CONFIG_RESET   = 16'hC810;
  localparam logic [15:0] CONFIG_RW_MASK = 16'hFE1F; // Writable bits
  localparam int RANGE_HI       = 15;
  localparam int RANGE_LO       = 12;
  localparam int CONV_TIME_BIT  = 11;
  localparam int MODE_HI        = 10;
  localparam int MODE_LO        = 9;
  localparam int OVF_BIT        = 8;
  localparam int DONE_FLAG_BIT  = 7;
  localparam int ABOVE_FLAG_BIT = 6;
  localparam int BELOW_FLAG_BIT = 5;
  localparam int ZERO_BIT       = 2;
  localparam int EXP_HI         = 15;
  localparam int EXP_LO         = 12;

  localparam logic [3:0] RANGE_AUTO    = 4'hC;
  localparam logic [3:0] RANGE_R5      = 4'h5;
  localparam logic [3:0] RANGE_R0      = 4'h0;
  localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
  localparam logic [1:0] MODE_SINGLE   = 2'h1;

  // Mantissa masks for reduced resolution
  localparam logic [11:0] MASK_FULL  = 12'hFFF;
  localparam logic [11:0] MASK_DROP1 = 12'hFFE;
  localparam logic [11:0] MASK_DROP2 = 12'hFFC;
  localparam logic [11:0] MASK_DROP3 = 12'hFF8;

  // ==========================================================
  // Interrupt status layout
  localparam int IRQ_W       = 2;
  localparam int IRQ_DONE    = 0;
  localparam int IRQ_OVF     = 1;

  typedef enum logic {CONV_IDLE, CONV_RUN} convState_t;

  // Byte address of a register index on the 12-bit bus
  function automatic logic [11:0] regAddr(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction

  // Mantissa mask for a range at a conversion time
  function automatic logic [11:0] resMask(input logic [3:0] rng,
                                          input logic longConv);
    logic [11:0] m;
    m = MASK_FULL;
    if (!longConv) begin
      if (rng == RANGE_R0) m = MASK_DROP3;
      else if (rng < RANGE_R5) m = MASK_DROP2;
      else if (rng == RANGE_R5) m = MASK_DROP1;
    end
    return m;
  endfunction

endpackage

// [rtl/tick_divider.sv]
// Millisecond enable pulse divider
`timescale 1ns/1ps
module tick_divider #(
  parameter int unsigned DIV = 25000
) (
  input  wire logic core_clk,
  input  wire logic rstSync_n,
  input  wire logic clear,
  output logic      tick
);
  localparam int CW = $clog2(DIV);

  logic [CW-1:0] cnt_q; // Cycle count within one period
  logic [CW-1:0] cnt_d;

  // ==========================================================
  // Next count; clear realigns the grid to a conversion start
  always_comb begin
    tick  = (cnt_q == CW'(DIV - 1));
    cnt_d = cnt_q + 1'b1;
    if (clear || tick) cnt_d = '0;
  end

  // Register only
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) cnt_q <= '0;
    else cnt_q <= cnt_d;
  end
endmodule // tick_divider

// [rtl/light_sensor_config_control.sv]
// APB config register and conversion control of a light sensor
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
module light_sensor_config_control
  import lsc_pkg::*;
#(
  parameter int unsigned MS_TICK_CYCLES = CLK_FREQ_HZ / MS_PER_SEC,
  parameter logic [CONV_MS_W-1:0] SHORT_TICKS = CONV_MS_W'(SHORT_CONV_MS),
  parameter logic [CONV_MS_W-1:0] LONG_TICKS  = CONV_MS_W'(LONG_CONV_MS)
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [11:0] feMantissa,
  input  wire logic [3:0]  feAutoRange,
  input  wire logic        feOverflow,
  input  wire logic        feAboveLimit,
  input  wire logic        feBelowLimit,
  output logic             convActive,
  output logic             irq
);
  import lsc_pkg::*;

  // ==========================================================
  // Reset release synchroniser
  logic rstMeta_n;  // First stage, read by second only
  logic rstSync_n;  // Released reset for all logic

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_n <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_n <= 1'b1;
      rstSync_n <= rstMeta_n;
    end
  end

  // ==========================================================
  // State declarations
  convState_t           state_q, state_d;     // Conversion phase
  logic [CONV_MS_W-1:0] convMs_q, convMs_d;   // ms elapsed
  logic [15:0]          cfgRw_q, cfgRw_d;     // Writable fields
  logic                 ovf_q, ovf_d;         // Overflow flag
  logic                 doneFlag_q, doneFlag_d;   // Conversion done
  logic                 aboveFlag_q, aboveFlag_d; // Above limit flag
  logic                 belowFlag_q, belowFlag_d; // Below limit flag
  logic [15:0]          result_q, result_d;   // Result word
  logic [IRQ_W-1:0]     irqSts_q, irqSts_d;   // Sticky events
  logic [IRQ_W-1:0]     irqMask_q, irqMask_d; // Event enables
  logic [31:0]          prdata_q, prdata_d;   // Captured read

  logic        msTick;     // One pulse per ms
  logic        divClear;   // Realign ms grid
  logic        accessDone; // APB access completes
  logic        wrCfg;      // Config write taken
  logic        rdCfg;      // Config read taken
  logic        rdSts;      // Status read taken
  logic        wrMask;     // Mask write taken
  logic        mapped;     // Address decodes
  logic        convEnd;    // Conversion finishes now
  logic [1:0]  newMode;    // Mode in written word
  logic [15:0] cfgRead;    // Config as seen by reads
  logic [3:0]  rangeSel;   // Current range field
  logic [1:0]  modeSel;    // Current mode field
  logic [CONV_MS_W-1:0] target; // Conversion length in ms
  logic [3:0]  expCode;    // Exponent of new result
  logic [3:0]  fsRange;    // Range in force for new result
  logic [31:0] rdMux;      // Read data selection

  tick_divider #(
    .DIV (MS_TICK_CYCLES)
  ) u_ms (
    .core_clk  (core_clk),
    .rstSync_n (rstSync_n),
    .clear     (divClear),
    .tick      (msTick)
  );

  // ==========================================================
  // Bus decode; zero wait states, so access ends on penable
  assign pready     = 1'b1;
  assign accessDone = psel && penable;
  assign mapped     = (paddr == regAddr(IDX_RESULT)) ||
                      (paddr == regAddr(IDX_CONFIG)) ||
                      (paddr == regAddr(IDX_IRQ_STATUS)) ||
                      (paddr == regAddr(IDX_IRQ_MASK));
  assign pslverr    = accessDone && !mapped;
  assign wrCfg  = accessDone && pwrite && paddr == regAddr(IDX_CONFIG);
  assign rdCfg  = accessDone && !pwrite && paddr == regAddr(IDX_CONFIG);
  assign rdSts  = accessDone && !pwrite &&
                  paddr == regAddr(IDX_IRQ_STATUS);
  assign wrMask = accessDone && pwrite &&
                  paddr == regAddr(IDX_IRQ_MASK);
  assign newMode = pwdata[MODE_HI:MODE_LO];

  // Status bits are merged over the stored writable fields
  assign cfgRead = {cfgRw_q[15:9], ovf_q, doneFlag_q, aboveFlag_q,
                    belowFlag_q, cfgRw_q[4:0]};
  assign rangeSel   = cfgRw_q[RANGE_HI:RANGE_LO];
  assign modeSel    = cfgRw_q[MODE_HI:MODE_LO];
  assign target     = cfgRw_q[CONV_TIME_BIT] ? LONG_TICKS : SHORT_TICKS;
  // A write in the last cycle aborts, so no end is reported then
  assign convEnd    = (state_q == CONV_RUN) && msTick && !wrCfg &&
                      (convMs_q == target - 1'b1);
  assign convActive = (state_q == CONV_RUN);
  assign prdata     = prdata_q;
  assign irq        = |(irqSts_q & irqMask_q);

  // ==========================================================
  // Read mux; sampled in setup so data stand through access
  always_comb begin
    rdMux = '0;
    unique case (1'b1)
      paddr == regAddr(IDX_RESULT):     rdMux[15:0] = result_q;
      paddr == regAddr(IDX_CONFIG):     rdMux[15:0] = cfgRead;
      paddr == regAddr(IDX_IRQ_STATUS): rdMux[IRQ_W-1:0] = irqSts_q;
      paddr == regAddr(IDX_IRQ_MASK):   rdMux[IRQ_W-1:0] = irqMask_q;
      default:                          rdMux = '0; // Unmapped
    endcase
  end

  // ==========================================================
  // Exponent: auto choice, manual range, or masked to zero
  always_comb begin
    // Range in force, kept apart from the possibly zeroed code
    fsRange = (rangeSel == RANGE_AUTO) ? feAutoRange : rangeSel;
    expCode = fsRange;
    if (cfgRw_q[ZERO_BIT] && rangeSel < RANGE_AUTO) begin
      expCode = '0;
    end
  end

  // ==========================================================
  // Conversion control and register next values
  always_comb begin
    state_d   = state_q;
    convMs_d  = convMs_q;
    cfgRw_d   = cfgRw_q;
    ovf_d     = ovf_q;
    doneFlag_d  = doneFlag_q;
    aboveFlag_d = aboveFlag_q;
    belowFlag_d = belowFlag_q;
    result_d  = result_q;
    irqSts_d  = irqSts_q;
    irqMask_d = irqMask_q;
    divClear  = 1'b0;
    prdata_d  = prdata_q;
    if (psel && !penable) prdata_d = rdMux;
    if (wrCfg) begin
      // Only writable bits land; status bits ignore the written data
      cfgRw_d  = pwdata[15:0] & CONFIG_RW_MASK;
      convMs_d = '0;
      divClear = 1'b1;
      if (newMode == MODE_SHUTDOWN) begin
        state_d = CONV_IDLE;
      end else begin
        state_d = CONV_RUN;
      end
    end else if (state_q == CONV_RUN && msTick) begin
      convMs_d = convMs_q + 1'b1;
      if (convEnd) begin
        convMs_d = '0;
        // Layout and weight do not depend on time, only masking
        // Resolution follows the real range even when code is zeroed
        result_d = {expCode, feMantissa &
                    resMask(fsRange, cfgRw_q[CONV_TIME_BIT])};
        ovf_d       = feOverflow;
        aboveFlag_d = feAboveLimit;
        belowFlag_d = feBelowLimit;
        if (modeSel == MODE_SINGLE) begin
          cfgRw_d[MODE_HI:MODE_LO] = MODE_SHUTDOWN;
          state_d = CONV_IDLE;
        end
      end
    end
    // Clear only what was reported, so a late event survives
    if (rdCfg && prdata_q[DONE_FLAG_BIT]) doneFlag_d = 1'b0;
    if (wrCfg && newMode != MODE_SHUTDOWN) doneFlag_d = 1'b0;
    if (convEnd) doneFlag_d = 1'b1;
    if (rdSts) irqSts_d = irqSts_q & ~prdata_q[IRQ_W-1:0];
    if (convEnd) begin
      irqSts_d[IRQ_DONE] = 1'b1;
      if (feOverflow) irqSts_d[IRQ_OVF] = 1'b1;
    end
    if (wrMask) irqMask_d = pwdata[IRQ_W-1:0];
  end

  // Register only
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      state_q   <= CONV_IDLE;
      convMs_q  <= '0;
      cfgRw_q   <= CONFIG_RESET & CONFIG_RW_MASK;
      ovf_q     <= CONFIG_RESET[OVF_BIT];
      doneFlag_q  <= CONFIG_RESET[DONE_FLAG_BIT];
      aboveFlag_q <= CONFIG_RESET[ABOVE_FLAG_BIT];
      belowFlag_q <= CONFIG_RESET[BELOW_FLAG_BIT];
      result_q  <= '0;
      irqSts_q  <= '0;
      irqMask_q <= '0;
      prdata_q  <= '0;
    end else begin
      state_q   <= state_d;
      convMs_q  <= convMs_d;
      cfgRw_q   <= cfgRw_d;
      ovf_q     <= ovf_d;
      doneFlag_q  <= doneFlag_d;
      aboveFlag_q <= aboveFlag_d;
      belowFlag_q <= belowFlag_d;
      result_q  <= result_d;
      irqSts_q  <= irqSts_d;
      irqMask_q <= irqMask_d;
      prdata_q  <= prdata_d;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstSync_n);

  // Cycle count since conversion start, for duration check
  logic [31:0] runCyc_q;
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) runCyc_q <= '0;
    else if (wrCfg || convEnd) runCyc_q <= '0;
    else if (state_q == CONV_RUN) runCyc_q <= runCyc_q + 1'b1;
  end

  sequence sStartWrite;
    wrCfg && newMode != MODE_SHUTDOWN;
  endsequence

  sequence sStopWrite;
    wrCfg && newMode == MODE_SHUTDOWN;
  endsequence

  sequence sFreshRun;
    state_q == CONV_RUN && convMs_q == '0 && runCyc_q == '0;
  endsequence

  chk_reset_config: assert property (
    !$past(rstSync_n) |-> cfgRead == CONFIG_RESET && !convActive)
    else $error("Config not at reset value after release");

  chk_abort_stop: assert property (
    sStopWrite |=> state_q == CONV_IDLE)
    else $error("Shutdown write did not abort conversion");

  chk_restart_run: assert property (
    sStartWrite |=> sFreshRun)
    else $error("Write did not start a fresh conversion");

  chk_conv_length: assert property (
    convEnd |-> runCyc_q ==
      32'(target) * 32'(MS_TICK_CYCLES) - 32'd1)
    else $error("Conversion length wrong");

  chk_single_stop: assert property (
    convEnd && modeSel == MODE_SINGLE |=>
      modeSel == MODE_SHUTDOWN && state_q == CONV_IDLE)
    else $error("Single shot did not return to shutdown");

  chk_cont_again: assert property (
    convEnd && modeSel[1] |=> sFreshRun ##1 convActive[*2])
    else $error("Continuous mode did not restart");

  chk_flags_kept: assert property (
    sStopWrite |=> $stable(ovf_q) && $stable(aboveFlag_q) &&
      $stable(belowFlag_q) && $stable(doneFlag_q) && $stable(irq))
    else $error("Shutdown write changed flags");

  chk_ro_ignored: assert property (
    wrCfg |=> ovf_q == $past(ovf_q) &&
      aboveFlag_q == $past(aboveFlag_q) &&
      belowFlag_q == $past(belowFlag_q))
    else $error("Write changed read-only bits");

  chk_done_set: assert property (
    convEnd |=> doneFlag_q && irqSts_q[IRQ_DONE])
    else $error("Done flag not set at conversion end");

  chk_done_clear: assert property (
    rdCfg && prdata_q[DONE_FLAG_BIT] && !convEnd |=> !doneFlag_q)
    else $error("Done flag not cleared by read");

  chk_exp_zero: assert property (
    convEnd && cfgRw_q[ZERO_BIT] && rangeSel < RANGE_AUTO |=>
      result_q[EXP_HI:EXP_LO] == '0)
    else $error("Exponent not zeroed");

  chk_auto_exp: assert property (
    convEnd && rangeSel == RANGE_AUTO |=>
      result_q[EXP_HI:EXP_LO] == $past(feAutoRange))
    else $error("Auto range code not reported");

  chk_short_res: assert property (
    convEnd && !cfgRw_q[CONV_TIME_BIT] && fsRange == RANGE_R0 |=>
      (result_q[EXP_LO-1:0] & ~MASK_DROP3) == '0)
    else $error("Resolution not reduced");

endmodule // light_sensor_config_control

// [dv/host_apb_model.sv]
// Host side APB master model for the sensor register block
`timescale 1ns/1ps
module host_apb_model (
  input  wire logic        core_clk,
  input  wire logic        pready,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata
);
  // ==========================================================
  // Idle bus from time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
  end

  // ==========================================================
  // One transfer; the caller stands just past a rising edge
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Request held until pready is sampled high
    do begin
      @(posedge core_clk);
      n++;
    end while (!pready && n < 32);
    if (!pready) tb.giveUp();
    psel    <= 1'b0;
    penable <= 1'b0;
    // Idle edge, so a following setup never shares this step
    @(posedge core_clk);
  endtask
endmodule // host_apb_model

// [dv/tb.sv]
// Self-checking bench for the light sensor config block
`timescale 1ns/1ps
`define CHECK(act, exp) begin nCompared++; if ((act) !== (exp)) begin \
  nErrors++; $display("ERROR t=%0t act=%h exp=%h", $time, act, exp); \
  end end
module tb;
  import lsc_pkg::*;
  // ==========================================================
  // Clock, reset and stimulus
  logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr, feMantissa;
  logic [31:0] pwdata, prdata;
  logic [3:0]  feAutoRange;
  logic        feOverflow, feAboveLimit, feBelowLimit, convActive, irq;
  logic [32:0] expQ[$];        // Expected {pslverr, prdata} per read
  int          nErrors, nCompared;
  integer      seed = 32'he8140710;
  // Single-shot and continuous settings; no reserved range code used
  logic [15:0] cfgs [11] = '{16'hC204, 16'h0204, 16'h1204, 16'h4204,
    16'h5204, 16'h6204, 16'hB200, 16'h0A04, 16'h3200,
    16'h2404, 16'h7E04};

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  host_apb_model host (.core_clk(core_clk), .pready(pready),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata));

  // Short counts keep each conversion to 12 or 20 cycles
  light_sensor_config_control #(.MS_TICK_CYCLES(4),
    .SHORT_TICKS(CONV_MS_W'(3)), .LONG_TICKS(CONV_MS_W'(5)))
  i_light_sensor_config_control (.core_clk(core_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .feMantissa(feMantissa),
    .feAutoRange(feAutoRange), .feOverflow(feOverflow),
    .feAboveLimit(feAboveLimit), .feBelowLimit(feBelowLimit),
    .convActive(convActive), .irq(irq));

  // ==========================================================
  // Read monitor: each completed read takes the oldest note
  always @(posedge core_clk) begin
    if (psel && penable && pready && !pwrite) begin
      if (expQ.size() == 0) giveUp();
      else `CHECK({pslverr, prdata}, expQ.pop_front())
    end
  end

  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    host.xfer(1'b1, {2'h0, idx, 2'h0}, {16'h0000, d});
  endtask

  task automatic rd(input logic [7:0] idx, input logic [32:0] e);
    expQ.push_back(e);
    host.xfer(1'b0, {2'h0, idx, 2'h0}, 32'h0000_0000);
  endtask

  // Mantissa bits kept for a range and conversion time
  function automatic logic [11:0] keep(input logic [3:0] r,
                                       input logic lng);
    if (lng || r > 4'h5) return 12'hFFF;
    if (r == 4'h5) return 12'hFFE;
    if (r == 4'h0) return 12'hFF8;
    return 12'hFFC;
  endfunction

  // One conversion, two in continuous mode, with fresh front-end data, then result check
  task automatic run(input logic [15:0] cfg);
    logic [11:0] m;
    logic [3:0]  a, e, r;
    int          n;
    m = 12'($random(seed));
    a = 4'($unsigned($random(seed)) % 12);
    feMantissa  <= m;
    feAutoRange <= a;
    @(posedge core_clk);
    wr(IDX_CONFIG, cfg);
    n = 0;
    if (cfg[10]) begin
      // Continuous: let two ends pass, then stop by shutdown write
      repeat (cfg[11] ? 40 : 26) @(posedge core_clk);
      wr(IDX_CONFIG, {cfg[15:11], 2'h0, cfg[8:0]});
    end else begin
      while (convActive && n < 100) begin
        @(posedge core_clk);
        n++;
      end
      `CHECK(n, (cfg[11] ? 5 : 3) * 4)
    end
    // Resolution follows the range in force, auto choice included
    r = (cfg[15:12] == 4'hC) ? a : cfg[15:12];
    e = (cfg[15:12] == 4'hC) ? a : (cfg[2] ? 4'h0 : cfg[15:12]);
    rd(IDX_RESULT, {17'h0, e, m & keep(r, cfg[11])});
  endtask

  // ==========================================================
  // Verdict, reached from the end of the run or a hang
  task automatic results();
    if (nErrors == 0 && nCompared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic giveUp();
    nErrors++;
    results();
  endtask

  initial begin
    nErrors = 0;
    nCompared = 0;
    rst_n = 1'b0;
    feMantissa = 12'h000;
    feAutoRange = 4'h0;
    feOverflow = 1'b1;
    feAboveLimit = 1'b1;
    feBelowLimit = 1'b0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    // Reset values, refused and ignored accesses
    rd(IDX_CONFIG, {17'h0, 16'hC810});
    rd(IDX_IRQ_STATUS, 33'h0);
    rd(IDX_IRQ_MASK, 33'h0);
    wr(IDX_RESULT, 16'hFFFF);
    rd(IDX_RESULT, 33'h0);
    rd(8'h02, {1'b1, 32'h0});
    wr(IDX_CONFIG, 16'hC9E4);
    rd(IDX_CONFIG, {17'h0, 16'hC804});
    // Single shot in auto range, done flag and interrupt
    run(16'hCA00);
    rd(IDX_CONFIG, {17'h0, 16'hC9C0});
    rd(IDX_CONFIG, {17'h0, 16'hC940});
    `CHECK(irq, 1'b0)
    wr(IDX_IRQ_MASK, 16'h0001);
    rd(IDX_IRQ_MASK, 33'h1);
    `CHECK(irq, 1'b1)
    rd(IDX_IRQ_STATUS, 33'h3);
    @(posedge core_clk);
    `CHECK(irq, 1'b0)
    // Mode reads single while busy; rewrite aborts and restarts
    wr(IDX_CONFIG, 16'h5200);
    rd(IDX_CONFIG, {17'h0, 16'h5340});
    // New front-end levels, so the flags must follow the next end
    feOverflow   <= 1'b0;
    feBelowLimit <= 1'b1;
    run(16'h5A00);
    wr(IDX_CONFIG, 16'h5800);
    rd(IDX_CONFIG, {17'h0, 16'h58E0});
    wr(IDX_CONFIG, 16'h5400);
    repeat (3) @(posedge core_clk);
    wr(IDX_CONFIG, 16'h5000);
    `CHECK(convActive, 1'b0)
    rd(IDX_CONFIG, {17'h0, 16'h5060});
    foreach (cfgs[i]) run(cfgs[i]);
    repeat (4) @(posedge core_clk);
    `CHECK(expQ.size(), 0)
    results();
  end
endmodule // tb
